// >>> core/aac_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module aac_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] lvl_o,
	output logic      [W-1:0] rise_o
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
	} aac_sync_state_t;

	aac_sync_state_t s_q;
	aac_sync_state_t s_d;

	// s1 feeds only s2; the level moves once s2 and s3 agree
	always_comb begin
		s_d      = s_q;
		s_d.s1   = pin_i;
		s_d.s2   = s_q.s1;
		s_d.s3   = s_q.s2;
		s_d.lvl  = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 ^ s_q.s3));
		s_d.rise = s_d.lvl & ~s_q.lvl;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lvl_o  = s_q.lvl;
	assign rise_o = s_q.rise;
endmodule
`default_nettype wire

// >>> core/aac_pkg.sv
// constants shared by the amplifier control and status register bank
package aac_pkg;
	// ==========================================================
	// register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] OFF_IDENT    = 8'h01;
	localparam logic [7:0] OFF_ERR      = 8'h02;
	localparam logic [7:0] OFF_SYSCTL1  = 8'h03;
	localparam logic [7:0] OFF_FMT      = 8'h04;
	localparam logic [7:0] OFF_SYSCTL2  = 8'h05;
	localparam logic [7:0] OFF_SMUTE    = 8'h06;
	localparam logic [7:0] OFF_MVOL     = 8'h07;
	localparam logic [7:0] OFF_C1VOL    = 8'h08;
	localparam logic [7:0] OFF_C2VOL    = 8'h09;

	// ==========================================================
	// identification (value is arbitrary)
	localparam logic [6:0] IDENT_CODE   = 7'h2A;

	// ==========================================================
	// values after reset
	localparam logic [7:0] RST_ERR      = 8'h00;
	localparam logic [7:0] RST_SYSCTL1  = 8'hA0;
	localparam logic [7:0] RST_FMT      = 8'h05;
	localparam logic [7:0] RST_SYSCTL2  = 8'h40;
	localparam logic [7:0] RST_SMUTE    = 8'h00;
	localparam logic [7:0] RST_MVOL     = 8'hFF;
	localparam logic [7:0] RST_CVOL     = 8'h30;

	// writable bits; the rest read as zero
	localparam logic [7:0] MASK_SYSCTL1 = 8'hA3;
	localparam logic [7:0] MASK_FMT     = 8'h0F;
	localparam logic [7:0] MASK_SYSCTL2 = 8'h40;
	localparam logic [7:0] MASK_SMUTE   = 8'h03;

	// ==========================================================
	// field positions
	localparam int ERR_MCLK  = 7;
	localparam int ERR_PLL   = 6;
	localparam int ERR_SCLK  = 5;
	localparam int ERR_LRCLK = 4;
	localparam int ERR_SLIP  = 3;
	localparam int ERR_FAULT = 1;
	localparam int ERR_OTW   = 0;
	localparam int SC1_DCB   = 7;
	localparam int SC1_HARD  = 5;
	localparam int SC1_DEM   = 0;
	localparam int SC2_SHDN  = 6;
	localparam int SM_CH1    = 0;
	localparam int SM_CH2    = 1;

	// ==========================================================
	// encodings
	localparam logic [1:0] DEEMPH_NONE = 2'h0;
	localparam logic [1:0] DEEMPH_RSVD = 2'h1;
	localparam logic [3:0] FMT_LAST    = 4'h8;
	localparam logic [7:0] VOL_0DB     = 8'h30;
	localparam logic [7:0] VOL_RSVD_LO = 8'hCF;
	localparam logic [7:0] VOL_MUTE    = 8'hFF;

	// ==========================================================
	// pin inputs and clock monitor
	localparam int PIN_N     = 6;
	localparam int PIN_MCLK  = 0;
	localparam int PIN_SCLK  = 1;
	localparam int PIN_LRCLK = 2;
	localparam int PIN_PLL   = 3;
	localparam int PIN_FAULT = 4;
	localparam int PIN_OTW   = 5;
	localparam int CNT_W     = 16;
	localparam logic [CNT_W-1:0] EDGE_TOL = 16'h0001;
	localparam logic [CNT_W-1:0] PER_TOL  = 16'h0004;
	localparam logic [CNT_W-1:0] SLIP_TOL = 16'h0008;
endpackage

// >>> core/aac_regs.sv
// control and status register bank of the stereo class-d amplifier
`timescale 1ns/1ps
`default_nettype none
module aac_regs (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       mclk_i,
	input  wire logic       sclk_i,
	input  wire logic       lrclk_i,
	input  wire logic       pll_fail_i,
	input  wire logic       prot_fault_i,
	input  wire logic       temp_warn_i,
	output logic      [7:0] err_flags_o,
	output logic            clk_err_o,
	output logic            dc_block_en_o,
	output logic            hard_unmute_o,
	output logic      [1:0] deemph_o,
	output logic      [3:0] serial_fmt_o,
	output logic            fmt_rsvd_o,
	output logic            shutdown_o,
	output logic      [1:0] soft_mute_o,
	output logic      [7:0] master_vol_o,
	output logic      [7:0] ch1_vol_o,
	output logic      [7:0] ch2_vol_o,
	output logic      [2:0] vol_mute_o
);
	localparam int CW = aac_pkg::CNT_W;

	// ==========================================================
	// pin synchronisers
	logic [aac_pkg::PIN_N-1:0] pin_lvl;
	logic [aac_pkg::PIN_N-1:0] pin_rise;

	aac_pin_sync #(
		.W(aac_pkg::PIN_N)
	) u_sync (
		.clk_i (clk_i),
		.nrst_i(nrst_i),
		.pin_i ({temp_warn_i, prot_fault_i, pll_fail_i,
		         lrclk_i, sclk_i, mclk_i}),
		.lvl_o (pin_lvl),
		.rise_o(pin_rise)
	);

	logic mclk_rise;
	logic sclk_rise;
	logic lr_rise;
	assign mclk_rise = pin_rise[aac_pkg::PIN_MCLK];
	assign sclk_rise = pin_rise[aac_pkg::PIN_SCLK];
	assign lr_rise   = pin_rise[aac_pkg::PIN_LRCLK];

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0]    err;
		logic [7:0]    sc1;
		logic [7:0]    fmt;
		logic [7:0]    sc2;
		logic [7:0]    smute;
		logic [7:0]    mvol;
		logic [7:0]    c1vol;
		logic [7:0]    c2vol;
		logic [7:0]    rdata;
		logic [CW-1:0] mcnt;
		logic [CW-1:0] scnt;
		logic [CW-1:0] pcnt;
		logic [CW-1:0] mref;
		logic [CW-1:0] sref;
		logic [CW-1:0] pref;
		logic [CW-1:0] fcnt;
		logic          seen;
		logic          valid;
	} aac_regs_state_t;

	aac_regs_state_t s_q;
	aac_regs_state_t s_d;
	logic [7:0]      setv;

	// absolute difference above a tolerance
	function automatic logic diff_gt(input logic [CW-1:0] a,
	                                 input logic [CW-1:0] b,
	                                 input logic [CW-1:0] tol);
		logic [CW-1:0] d;
		d = (a > b) ? a - b : b - a;
		return d > tol;
	endfunction

	// saturating increment so a stopped frame clock cannot wrap
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] a,
	                                          input logic          en);
		return (en && a != {CW{1'b1}}) ? a + 1'b1 : a;
	endfunction

	// ==========================================================
	// clock monitor, error flags and register file
	always_comb begin
		logic          wr_err;
		logic          phase_bad;
		logic [CW-1:0] ph_far;
		wr_err    = 1'b0;
		phase_bad = 1'b0;
		ph_far    = '0;
		s_d       = s_q;
		setv      = 8'h00;

		s_d.mcnt = sat_inc(s_q.mcnt, mclk_rise);
		s_d.scnt = sat_inc(s_q.scnt, sclk_rise);
		s_d.pcnt = sat_inc(s_q.pcnt, 1'b1);
		// internal frame sync free-runs at the last measured period
		if (s_q.valid && s_q.fcnt >= s_q.pref - 1'b1) begin
			s_d.fcnt = '0;
		end else begin
			s_d.fcnt = s_q.fcnt + 1'b1;
		end

		if (lr_rise) begin
			if (s_q.valid) begin
				if (diff_gt(s_q.mcnt, s_q.mref, aac_pkg::EDGE_TOL)) begin
					setv[aac_pkg::ERR_MCLK] = 1'b1;
				end
				if (diff_gt(s_q.scnt, s_q.sref, aac_pkg::EDGE_TOL)) begin
					setv[aac_pkg::ERR_SCLK] = 1'b1;
				end
				if (diff_gt(s_q.pcnt, s_q.pref, aac_pkg::PER_TOL)) begin
					setv[aac_pkg::ERR_LRCLK] = 1'b1;
				end
				// edge should land where the internal frame wraps
				ph_far    = s_q.pref - s_q.fcnt;
				phase_bad = s_q.fcnt > aac_pkg::SLIP_TOL &&
				            ph_far > aac_pkg::SLIP_TOL;
				if (phase_bad) begin
					setv[aac_pkg::ERR_SLIP] = 1'b1;
				end
			end
			// realign only when needed so slow drift stays visible
			if (!s_q.valid || phase_bad) begin
				s_d.fcnt = '0;
			end
			s_d.mref  = s_q.mcnt;
			s_d.sref  = s_q.scnt;
			s_d.pref  = s_q.pcnt;
			s_d.mcnt  = '0;
			s_d.scnt  = '0;
			s_d.pcnt  = {{(CW-1){1'b0}}, 1'b1};
			s_d.valid = s_q.seen;
			s_d.seen  = 1'b1;
		end

		// fault inputs raise their flags for as long as they stand
		setv[aac_pkg::ERR_PLL]   = pin_lvl[aac_pkg::PIN_PLL];
		setv[aac_pkg::ERR_FAULT] = pin_lvl[aac_pkg::PIN_FAULT];
		setv[aac_pkg::ERR_OTW]   = pin_lvl[aac_pkg::PIN_OTW];

		if (wr_i) begin
			case (addr_i)
				aac_pkg::OFF_ERR:     wr_err = 1'b1;
				aac_pkg::OFF_SYSCTL1: begin
					s_d.sc1 = wdata_i & aac_pkg::MASK_SYSCTL1;
				end
				aac_pkg::OFF_FMT: begin
					s_d.fmt = wdata_i & aac_pkg::MASK_FMT;
				end
				aac_pkg::OFF_SYSCTL2: begin
					s_d.sc2 = wdata_i & aac_pkg::MASK_SYSCTL2;
				end
				aac_pkg::OFF_SMUTE: begin
					s_d.smute = wdata_i & aac_pkg::MASK_SMUTE;
				end
				aac_pkg::OFF_MVOL:  s_d.mvol  = wdata_i;
				aac_pkg::OFF_C1VOL: s_d.c1vol = wdata_i;
				aac_pkg::OFF_C2VOL: s_d.c2vol = wdata_i;
				default: ;
			endcase
		end

		// zeros written clear, ones keep; a new event wins the cycle
		s_d.err = (wr_err ? (s_q.err & wdata_i) : s_q.err) | setv;

		s_d.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				aac_pkg::OFF_IDENT:   s_d.rdata = {1'b0, aac_pkg::IDENT_CODE};
				aac_pkg::OFF_ERR:     s_d.rdata = s_q.err;
				aac_pkg::OFF_SYSCTL1: s_d.rdata = s_q.sc1;
				aac_pkg::OFF_FMT:     s_d.rdata = s_q.fmt;
				aac_pkg::OFF_SYSCTL2: s_d.rdata = s_q.sc2;
				aac_pkg::OFF_SMUTE:   s_d.rdata = s_q.smute;
				aac_pkg::OFF_MVOL:    s_d.rdata = s_q.mvol;
				aac_pkg::OFF_C1VOL:   s_d.rdata = s_q.c1vol;
				aac_pkg::OFF_C2VOL:   s_d.rdata = s_q.c2vol;
				default:              s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_q       <= '0;
			s_q.err   <= aac_pkg::RST_ERR;
			s_q.sc1   <= aac_pkg::RST_SYSCTL1;
			s_q.fmt   <= aac_pkg::RST_FMT;
			s_q.sc2   <= aac_pkg::RST_SYSCTL2;
			s_q.smute <= aac_pkg::RST_SMUTE;
			s_q.mvol  <= aac_pkg::RST_MVOL;
			s_q.c1vol <= aac_pkg::RST_CVOL;
			s_q.c2vol <= aac_pkg::RST_CVOL;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	logic [7:0] err_clk_mask;
	assign err_clk_mask = (8'h01 << aac_pkg::ERR_MCLK) |
	                      (8'h01 << aac_pkg::ERR_SCLK) |
	                      (8'h01 << aac_pkg::ERR_LRCLK) |
	                      (8'h01 << aac_pkg::ERR_SLIP);

	assign rdata_o       = s_q.rdata;
	assign err_flags_o   = s_q.err;
	// audio path uses this with hard_unmute_o to pick its recovery
	assign clk_err_o     = |(s_q.err & err_clk_mask);
	assign dc_block_en_o = s_q.sc1[aac_pkg::SC1_DCB];
	assign hard_unmute_o = s_q.sc1[aac_pkg::SC1_HARD];
	assign deemph_o      = s_q.sc1[aac_pkg::SC1_DEM +: 2];
	assign serial_fmt_o  = s_q.fmt[3:0];
	assign fmt_rsvd_o    = s_q.fmt[3:0] > aac_pkg::FMT_LAST;
	assign shutdown_o    = s_q.sc2[aac_pkg::SC2_SHDN];
	assign soft_mute_o   = {s_q.smute[aac_pkg::SM_CH2],
	                        s_q.smute[aac_pkg::SM_CH1]};
	assign master_vol_o  = s_q.mvol;
	assign ch1_vol_o     = s_q.c1vol;
	assign ch2_vol_o     = s_q.c2vol;
	// reserved volume codes are played as mute: safest for speakers
	assign vol_mute_o    = {s_q.c2vol >= aac_pkg::VOL_RSVD_LO,
	                        s_q.c1vol >= aac_pkg::VOL_RSVD_LO,
	                        s_q.mvol  >= aac_pkg::VOL_RSVD_LO};

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	ident_read_a: assert property (
		rd_i && addr_i == aac_pkg::OFF_IDENT
		|=> rdata_o == {1'b0, aac_pkg::IDENT_CODE})
		else $error("identification read wrong");

	err_sticky_a: assert property (
		!(wr_i && addr_i == aac_pkg::OFF_ERR)
		|=> (err_flags_o & $past(err_flags_o)) == $past(err_flags_o))
		else $error("error flag dropped without a write");

	err_clear_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_ERR
		|=> err_flags_o == (($past(err_flags_o) & $past(wdata_i))
		                    | $past(setv)))
		else $error("error flag clear wrong");

	mclk_flag_a: assert property (
		lr_rise && s_q.valid &&
		diff_gt(s_q.mcnt, s_q.mref, aac_pkg::EDGE_TOL)
		|=> err_flags_o[aac_pkg::ERR_MCLK])
		else $error("master clock change not flagged");

	sclk_flag_a: assert property (
		lr_rise && s_q.valid &&
		diff_gt(s_q.scnt, s_q.sref, aac_pkg::EDGE_TOL)
		|=> err_flags_o[aac_pkg::ERR_SCLK])
		else $error("bit clock change not flagged");

	lrclk_flag_a: assert property (
		lr_rise && s_q.valid &&
		diff_gt(s_q.pcnt, s_q.pref, aac_pkg::PER_TOL)
		|=> err_flags_o[aac_pkg::ERR_LRCLK])
		else $error("frame clock change not flagged");

	slip_flag_a: assert property (
		setv[aac_pkg::ERR_SLIP]
		|=> err_flags_o[aac_pkg::ERR_SLIP] && s_q.fcnt == '0)
		else $error("frame slip not flagged or not realigned");

	fault_flag_a: assert property (
		$rose(pin_lvl[aac_pkg::PIN_FAULT])
		|-> ##1 err_flags_o[aac_pkg::ERR_FAULT] [*2])
		else $error("protection fault not flagged");

	reset_vals_a: assert property (
		$rose(nrst_i) |-> dc_block_en_o && hard_unmute_o &&
		shutdown_o && serial_fmt_o == aac_pkg::RST_FMT[3:0] &&
		master_vol_o == aac_pkg::VOL_MUTE &&
		ch1_vol_o == aac_pkg::VOL_0DB && deemph_o == aac_pkg::DEEMPH_NONE)
		else $error("reset values wrong");

	smute_wr_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_SMUTE
		|=> soft_mute_o == $past(wdata_i[1:0]))
		else $error("soft mute write not applied");

	fmt_read_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_FMT ##1
		rd_i && addr_i == aac_pkg::OFF_FMT && !wr_i
		|=> rdata_o == {4'h0, $past(wdata_i[3:0], 2)})
		else $error("format readback wrong");

	dcb_write_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_SYSCTL1
		|=> dc_block_en_o == $past(wdata_i[aac_pkg::SC1_DCB]))
		else $error("dc blocking write not applied");

	shutdown_write_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_SYSCTL2
		|=> shutdown_o == $past(wdata_i[aac_pkg::SC2_SHDN]))
		else $error("shutdown write not applied");

	ch2_vol_a: assert property (
		wr_i && addr_i == aac_pkg::OFF_C2VOL
		|=> ch2_vol_o == $past(wdata_i))
		else $error("channel two volume write not applied");

	deemph_rsvd_c: cover property (deemph_o == aac_pkg::DEEMPH_RSVD);
	slip_seen_c:   cover property (setv[aac_pkg::ERR_SLIP]);
	mclk_seen_c:   cover property (setv[aac_pkg::ERR_MCLK]);
	clear_race_c:  cover property (
		wr_i && addr_i == aac_pkg::OFF_ERR && setv != 8'h00);
endmodule
`default_nettype wire

// >>> tb/aac_clk_src.sv
// audio clock source model feeding the amplifier's clock pins
`timescale 1ns/1ps
`default_nettype none
module aac_clk_src (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       en_i,
	input  wire logic [7:0] mh_i,
	input  wire logic [7:0] sh_i,
	input  wire logic [7:0] lh_i,
	input  wire logic       slip_i,
	output logic            mclk_o,
	output logic            sclk_o,
	output logic            lrclk_o
);
	// ==========================================================
	// half-period counters
	// a stopped source parks every clock low, so no frame edges appear
	logic [7:0] mc_q;
	logic [7:0] sc_q;
	logic [7:0] lc_q;
	logic       pend_q;
	logic [7:0] lim;

	// a slip stretches one frame-clock half by 12 cycles, shifting phase
	assign lim = lh_i + (pend_q ? 8'h0C : 8'h00);

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_i) begin
			{mc_q, sc_q, lc_q, pend_q} <= '0;
			{mclk_o, sclk_o, lrclk_o} <= '0;
		end else begin
			mc_q <= (mc_q + 8'h01 >= mh_i) ? 8'h00 : mc_q + 8'h01;
			sc_q <= (sc_q + 8'h01 >= sh_i) ? 8'h00 : sc_q + 8'h01;
			if (mc_q + 8'h01 >= mh_i) mclk_o <= ~mclk_o;
			if (sc_q + 8'h01 >= sh_i) sclk_o <= ~sclk_o;
			if (slip_i) pend_q <= 1'b1;
			if (lc_q + 8'h01 >= lim) begin
				lc_q    <= 8'h00;
				lrclk_o <= ~lrclk_o;
				if (!slip_i) pend_q <= 1'b0;
			end else begin
				lc_q <= lc_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the amplifier control and status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
	// ==========================================================
	// signals
	logic       clk_i, nrst_i, wr, rd, en, slip;
	logic [7:0] addr, wdata, mh, sh, lh, rdata, err_flags;
	logic [7:0] mvol, c1vol, c2vol;
	logic [2:0] flt, vmute;
	logic [1:0] deemph, smute;
	logic [3:0] fmt;
	logic       mclk, sclk, lrclk, clk_err, dcb, hard, frsv, shdn;
	int         err_total, compares, cyc;

	aac_regs i_aac_regs (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.mclk_i(mclk), .sclk_i(sclk), .lrclk_i(lrclk),
		.pll_fail_i(flt[2]), .prot_fault_i(flt[1]), .temp_warn_i(flt[0]),
		.err_flags_o(err_flags), .clk_err_o(clk_err), .dc_block_en_o(dcb),
		.hard_unmute_o(hard), .deemph_o(deemph), .serial_fmt_o(fmt),
		.fmt_rsvd_o(frsv), .shutdown_o(shdn), .soft_mute_o(smute),
		.master_vol_o(mvol), .ch1_vol_o(c1vol), .ch2_vol_o(c2vol),
		.vol_mute_o(vmute));
	aac_clk_src i_aac_clk_src (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en),
		.mh_i(mh), .sh_i(sh), .lh_i(lh), .slip_i(slip), .mclk_o(mclk),
		.sclk_o(sclk), .lrclk_o(lrclk));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ==========================================================
	// bus tasks; reserved bits are written as zero except where masks are probed
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd <= 1'b1; addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// write then read back with no idle cycle between the strobes
	task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0; rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] ra[11];
		logic [7:0] ea[11];
		logic [7:0] d;
		ra = '{8'h00, aac_pkg::OFF_IDENT, aac_pkg::OFF_ERR,
			aac_pkg::OFF_SYSCTL1, aac_pkg::OFF_FMT, aac_pkg::OFF_SYSCTL2,
			aac_pkg::OFF_SMUTE, aac_pkg::OFF_MVOL, aac_pkg::OFF_C1VOL,
			aac_pkg::OFF_C2VOL, 8'h0A};
		ea = '{8'h00, {1'b0, aac_pkg::IDENT_CODE}, 8'h00, 8'hA0, 8'h05,
			8'h40, 8'h00, 8'hFF, 8'h30, 8'h30, 8'h00};
		`CHK({dcb, hard, deemph, fmt, shdn, smute}, 11'h62C)
		`CHK({mvol, c1vol, c2vol, vmute}, 27'h7F98181)
		for (int i = 0; i < 11; i++) begin
			rd_reg(ra[i], d);
			`CHK(d, ea[i])
		end
		@(posedge clk_i);
		#1 `CHK(rdata, 8'h00)
		$display("test reset done");
	endtask

	task automatic t_ctl();
		logic [7:0] d, v, vo;
		logic [7:0] vl[6];
		vl = '{8'h00, 8'h30, 8'hCE, 8'hCF, 8'hFE, 8'hFF};
		wr_reg(aac_pkg::OFF_SYSCTL1, 8'hFF);
		rd_reg(aac_pkg::OFF_SYSCTL1, d);
		`CHK({d, dcb, hard}, 10'h28F)
		for (int i = 0; i < 4; i++) begin
			wr_reg(aac_pkg::OFF_SYSCTL1, 8'(i));
			`CHK({dcb, hard, deemph}, 4'(i))
		end
		for (int i = 0; i < 16; i++) begin
			wr_rd_reg(aac_pkg::OFF_FMT, 8'hF0 | 8'(i), d);
			`CHK({d, fmt, frsv}, {8'(i), 4'(i), i > 8})
		end
		wr_reg(aac_pkg::OFF_SYSCTL2, 8'hFF);
		rd_reg(aac_pkg::OFF_SYSCTL2, d);
		`CHK({d, shdn}, 9'h081)
		wr_reg(aac_pkg::OFF_SYSCTL2, 8'h00);
		`CHK(shdn, 1'b0)
		for (int i = 0; i < 4; i++) begin
			wr_reg(aac_pkg::OFF_SMUTE, 8'hFC | 8'(i));
			rd_reg(aac_pkg::OFF_SMUTE, d);
			`CHK({d, smute}, {8'(i), 2'(i)})
		end
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 6; j++) begin
				v = vl[j];
				wr_reg(aac_pkg::OFF_MVOL + 8'(k), v);
				rd_reg(aac_pkg::OFF_MVOL + 8'(k), d);
				vo = (k == 0) ? mvol : (k == 1) ? c1vol : c2vol;
				`CHK({d, vo, vmute[k]}, {v, v, v >= 8'hCF})
			end
		end
		wr_reg(aac_pkg::OFF_IDENT, 8'h00);
		wr_reg(8'h0A, 8'h55);
		rd_reg(aac_pkg::OFF_IDENT, d);
		`CHK(d, {1'b0, aac_pkg::IDENT_CODE})
		rd_reg(8'h0A, d);
		`CHK(d, 8'h00)
		$display("test controls done");
	endtask

	task automatic t_faults();
		int         bp[3];
		logic [7:0] d;
		bp = '{6, 1, 0};
		for (int j = 0; j < 3; j++) begin
			@(posedge clk_i) flt <= 3'b100 >> j;
			wait_n(10);
			flt <= 3'b000;
			wait_n(10);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK({d, err_flags}, {2{8'h01 << bp[j]}})
			wr_reg(aac_pkg::OFF_ERR, 8'hFB);
			wait_n(20);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK(d, 8'h01 << bp[j])
			wr_reg(aac_pkg::OFF_ERR, 8'h00);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK(d, 8'h00)
			@(posedge clk_i) flt <= 3'b100 >> j;
			wait_n(10);
			wr_reg(aac_pkg::OFF_ERR, 8'h00);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK(d, 8'h01 << bp[j])
			@(posedge clk_i) flt <= 3'b000;
			wait_n(10);
			wr_reg(aac_pkg::OFF_ERR, 8'h00);
		end
		$display("test faults done");
	endtask

	task automatic t_clocks();
		logic [7:0] d;
		logic [7:0] cm[4];
		logic [7:0] cs[4];
		logic [7:0] cl[4];
		int         eb[4];
		cm = '{8'h04, 8'h02, 8'h02, 8'h02};
		cs = '{8'h04, 8'h08, 8'h04, 8'h04};
		cl = '{8'h40, 8'h40, 8'h48, 8'h40};
		eb = '{7, 5, 4, 3};
		@(posedge clk_i) en <= 1'b1;
		wait_n(1000);
		wr_reg(aac_pkg::OFF_ERR, 8'h00);
		wait_n(600);
		rd_reg(aac_pkg::OFF_ERR, d);
		`CHK({d, clk_err}, 9'h000)
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			mh <= cm[i]; sh <= cs[i]; lh <= cl[i]; slip <= (i == 3);
			@(posedge clk_i) slip <= 1'b0;
			wait_n(800);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK({d[eb[i]], clk_err}, 2'b11)
			@(posedge clk_i);
			mh <= 8'h02; sh <= 8'h04; lh <= 8'h40;
			wait_n(800);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK(d[eb[i]], 1'b1)
			wr_reg(aac_pkg::OFF_ERR, 8'h00);
			rd_reg(aac_pkg::OFF_ERR, d);
			`CHK({d, clk_err}, 9'h000)
		end
		$display("test clocks done");
	endtask

	// ==========================================================
	// main sequence and hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		{wr, rd, en, slip, flt, addr, wdata} = '0;
		mh = 8'h02; sh = 8'h04; lh = 8'h40;
		err_total = 0; compares = 0; cyc = 0;
		nrst_i = 1'b0;
		wait_n(2);
		nrst_i <= 1'b1;
		#1;
		t_reset();
		t_ctl();
		t_faults();
		t_clocks();
		finish_test();
	end
endmodule
`default_nettype wire
